// >>> verilog/tdc_ticket_dispense_control.sv
/*
  ticket dispense control: drives the dispenser motor and watches the
  passage sensor, one award issuing a count of tickets.
  assumes a 50 MHz clock, async active-low reset, sensor line resolved
  outside (open collector with pull-up) to a plain input.
*/
`timescale 1ns/100ps
`default_nettype none

module tdc_ticket_dispense_control #(
  parameter int unsigned TIMEOUT_CYCLES = tdc_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       award,
  input  wire logic       two_player,
  input  wire logic       enable_one,
  input  wire logic       enable_two,
  input  wire logic [7:0] tickets_per_award,
  input  wire logic       sense_in,
  output logic            motor_drive,
  output logic            busy,
  output logic            ticket_done,
  output logic            fault
);
  // -------------------------------------------------------------
  // sensor synchroniser
  // -------------------------------------------------------------
  logic sync_a;
  logic sync_b;
  logic sense;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sense  <= 1'b0;
    end else begin
      sync_a <= sense_in;
      sync_b <= sync_a;
      sense  <= sync_b;    // delayed copy for edge detection
    end
  end
  // high is blocked, low unblocked
  logic rise;
  logic fall;
  assign rise = sync_b & ~sense;
  assign fall = ~sync_b & sense;

  // -------------------------------------------------------------
  // dispense sequencer
  // -------------------------------------------------------------
  tdc_pkg::tdc_state_type state;
  tdc_pkg::tdc_state_type next_state;
  logic [tdc_pkg::TMR_W-1:0] tmr;
  logic [tdc_pkg::TMR_W-1:0] next_tmr;
  logic [tdc_pkg::CNT_W-1:0] left;
  logic [tdc_pkg::CNT_W-1:0] next_left;
  logic next_motor;
  logic next_done;
  logic next_fault;
  logic enabled;
  logic timed_out;

  assign enabled = two_player ? enable_two : enable_one;
  assign timed_out = (tmr >= tdc_pkg::TMR_W'(TIMEOUT_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_tmr   = tmr;
    next_left  = left;
    next_motor = 1'b0;
    next_done  = 1'b0;
    next_fault = 1'b0;
    case (state)
      tdc_pkg::TDC_IDLE: begin
        // an award with a zero count falls back to one ticket
        if (award && enabled) begin
          next_left  = (tickets_per_award == 8'h00) ?
                       tdc_pkg::DEFAULT_TICKETS : tickets_per_award;
          next_tmr   = '0;
          next_motor = 1'b1;
          next_state = tdc_pkg::TDC_WAIT_HIGH;
        end
      end
      tdc_pkg::TDC_WAIT_HIGH, tdc_pkg::TDC_WAIT_LOW: begin
        next_tmr   = tmr + 1'b1;
        next_motor = 1'b1;
        if (state == tdc_pkg::TDC_WAIT_HIGH && rise) begin
          next_state = tdc_pkg::TDC_WAIT_LOW;
        end
        if (timed_out) begin
          // abandon the rest of the award; a jam would only repeat
          next_motor = 1'b0;
          next_fault = 1'b1;
          next_left  = '0;
          next_state = tdc_pkg::TDC_IDLE;
        end else if (state == tdc_pkg::TDC_WAIT_LOW && fall) begin
          next_done = 1'b1;
          next_left = left - 1'b1;
          next_tmr  = '0;
          if (left == 8'h01) begin
            next_motor = 1'b0;
            next_state = tdc_pkg::TDC_IDLE;
          end else begin
            next_state = tdc_pkg::TDC_WAIT_HIGH;
          end
        end
      end
      default: begin
        next_state = tdc_pkg::TDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state       <= tdc_pkg::TDC_IDLE;
      tmr         <= '0;
      left        <= '0;
      motor_drive <= 1'b0;
      ticket_done <= 1'b0;
      fault       <= 1'b0;
    end else begin
      state       <= next_state;
      tmr         <= next_tmr;
      left        <= next_left;
      motor_drive <= next_motor;
      ticket_done <= next_done;
      fault       <= next_fault;
    end
  end

  assign busy = (state != tdc_pkg::TDC_IDLE);

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_motor_idle;
    @(posedge clk) disable iff (!nrst)
      (state == tdc_pkg::TDC_IDLE) |-> !motor_drive;
  endproperty
  a_motor_idle: assert property (p_motor_idle)
    else $error("motor runs while idle");

  property p_motor_busy;
    @(posedge clk) disable iff (!nrst)
      (state != tdc_pkg::TDC_IDLE) |-> motor_drive;
  endproperty
  a_motor_busy: assert property (p_motor_busy)
    else $error("motor stopped during dispense");

  property p_rise_moves;
    @(posedge clk) disable iff (!nrst)
      (state == tdc_pkg::TDC_WAIT_HIGH && rise && !timed_out)
        |=> (state == tdc_pkg::TDC_WAIT_LOW);
  endproperty
  a_rise_moves: assert property (p_rise_moves)
    else $error("blocked sensor not seen");

  property p_done_on_fall;
    @(posedge clk) disable iff (!nrst)
      (state == tdc_pkg::TDC_WAIT_LOW && fall && !timed_out) |=> ticket_done;
  endproperty
  a_done_on_fall: assert property (p_done_on_fall)
    else $error("ticket pass not counted");

  property p_timeout;
    @(posedge clk) disable iff (!nrst)
      (state != tdc_pkg::TDC_IDLE && timed_out)
        |=> (fault && !motor_drive && state == tdc_pkg::TDC_IDLE);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not stop motor");

  property p_fault_cause;
    @(posedge clk) disable iff (!nrst)
      $rose(fault) |-> $past(timed_out) && $past(busy);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault without timeout");

  property p_gate;
    @(posedge clk) disable iff (!nrst)
      (state == tdc_pkg::TDC_IDLE && award && !enabled)
        |=> (state == tdc_pkg::TDC_IDLE);
  endproperty
  a_gate: assert property (p_gate)
    else $error("dispense started while disabled");

  property p_count_load;
    @(posedge clk) disable iff (!nrst)
      (state == tdc_pkg::TDC_IDLE && award && enabled
       && tickets_per_award == 8'h00) |=> (left == 8'h01);
  endproperty
  a_count_load: assert property (p_count_load)
    else $error("default ticket count wrong");

  property p_tmr_bound;
    @(posedge clk) disable iff (!nrst)
      busy |-> (tmr < tdc_pkg::TMR_W'(TIMEOUT_CYCLES));
  endproperty
  a_tmr_bound: assert property (p_tmr_bound)
    else $error("dispense outlived its timeout");

  property p_sense_delay;
    @(posedge clk) disable iff (!nrst)
      rise |-> $past(sense_in, 2);
  endproperty
  a_sense_delay: assert property (p_sense_delay)
    else $error("sensor edge seen without synchroniser delay");

  c_start: cover property (@(posedge clk) disable iff (!nrst)
    $rose(motor_drive));
  c_done: cover property (@(posedge clk) disable iff (!nrst) ticket_done);
  c_fault: cover property (@(posedge clk) disable iff (!nrst) fault);
  c_multi: cover property (@(posedge clk) disable iff (!nrst)
    ticket_done && motor_drive);
endmodule // tdc_ticket_dispense_control
`default_nettype wire

// >>> verilog/tdc_pkg.sv
/*
  constants for the ticket dispense control block: timing, counts, widths.
  assumes a 50 MHz system clock.
*/
`default_nettype none
package tdc_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50000000;
  // dispense timeout, milliseconds (about a third of a second)
  localparam int unsigned TIMEOUT_MS      = 333;
  localparam int unsigned TIMEOUT_CYCLES  = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned TMR_W           = 25;
  // -------------------------------------------------------------
  // ticket count
  // -------------------------------------------------------------
  localparam int unsigned CNT_W           = 8;
  localparam logic [7:0]  DEFAULT_TICKETS = 8'h01;
  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    TDC_IDLE,
    TDC_WAIT_HIGH,
    TDC_WAIT_LOW
  } tdc_state_type;
endpackage
`default_nettype wire

// >>> tb/tdc_dispenser_model.sv
/*
  dispenser model: a motor-driven ticket feed with a passage sensor.
  assumes the sensor line is open collector with a pull-up on the board.
*/
`timescale 1ns/100ps
`default_nettype none
module tdc_dispenser_model (
  input  wire logic       clk,
  input  wire logic       motor_drive,
  input  wire logic       jam,
  input  wire logic [3:0] lag,
  output logic            sense_in
);
  // ---------------------------------------------------------------
  // feed
  // ---------------------------------------------------------------
  int cnt = 0;
  // a jammed feed never moves a ticket, so the sensor stays clear
  always @(posedge clk) begin
    cnt <= (motor_drive && !jam && cnt < lag + 6) ? cnt + 1 : 0;
  end
  // released to the pull-up while blocked, pulled low when clear
  assign sense_in = (cnt > lag) ? 1'b1 : 1'b0;
endmodule // tdc_dispenser_model
`default_nettype wire

// >>> tb/tb.sv
/*
  self-checking bench for the ticket dispense control block.
  assumes the dispenser model beside it; timeout shortened to 50 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) checks++; if ((a) !== (b)) begin \
  miscompares++; $display("Error at %0t: value mismatch", $time); end
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic       clk = 0, nrst = 0, award = 0, two_player = 0, jam = 0;
  logic       enable_one = 0, enable_two = 0;
  logic [7:0] tickets_per_award = 8'h00;
  logic [3:0] lag = 4'h6;
  logic       sense_in, motor_drive, busy, ticket_done, fault;
  int         miscompares = 0, checks = 0, n;
  localparam int TMO = 50;
  always #10 clk = ~clk;
  tdc_ticket_dispense_control #(.TIMEOUT_CYCLES(TMO)) dut (
    .clk(clk), .nrst(nrst), .award(award), .two_player(two_player),
    .enable_one(enable_one), .enable_two(enable_two),
    .tickets_per_award(tickets_per_award), .sense_in(sense_in),
    .motor_drive(motor_drive), .busy(busy), .ticket_done(ticket_done),
    .fault(fault));
  tdc_dispenser_model feed (
    .clk(clk), .motor_drive(motor_drive), .jam(jam), .lag(lag),
    .sense_in(sense_in));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // tickets the rules call for: none if disabled or jammed, zero means one
  function automatic int exp_tickets(input logic [7:0] cnt,
                                     input logic en, jm);
    if (!en || jm) begin
      return 0;
    end
    return (cnt == 8'h00) ? 1 : int'(cnt);
  endfunction
  // the wrong game type's enable is set on purpose when disabled;
  // a stray award and a new count mid-dispense must both be ignored
  task automatic run(input logic [7:0] cnt, input logic tp, en, jm);
    int d, f, b, i;
    d = 0;
    f = 0;
    b = 0;
    two_player = tp;
    enable_one = tp ? !en : en;
    enable_two = tp ? en : !en;
    tickets_per_award = cnt;
    jam = jm;
    lag = 4'(6 + $urandom % 8);
    award = 1;
    step;
    for (i = 0; i < 3000 && (i < 3 || busy === 1'b1); i++) begin
      award = (i == 5);
      if (i == 5) begin
        tickets_per_award = 8'($urandom);
      end
      d += (ticket_done === 1'b1);
      f += (fault === 1'b1);
      b += (busy === 1'b1);
      `CHK(motor_drive, busy)
      step;
    end
    // the last pulse stands in the cycle in which busy falls
    d += (ticket_done === 1'b1);
    f += (fault === 1'b1);
    if (i == 3000) begin
      miscompares++;
      $display("Error at %0t: dispense never ended", $time);
      end_of_test();
    end
    `CHK(d, exp_tickets(cnt, en, jm))
    `CHK(f, int'(en && jm))
    if (en && jm) begin
      `CHK(b, TMO)
    end
    $display("test done: count %0d jam %0d", cnt, jm);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(12));
    repeat (2) step;
    nrst = 1;
    run(8'h00, 1'b0, 1'b0, 1'b0);
    run(8'h00, 1'b1, 1'b0, 1'b0);
    run(8'h00, 1'b0, 1'b1, 1'b0);
    run(8'h01, 1'b1, 1'b1, 1'b0);
    repeat (5) begin
      n = 2 + $urandom % 4;
      run(8'(n), 1'($urandom), 1'b1, 1'b0);
    end
    run(8'h03, 1'b0, 1'b1, 1'b1);
    // reset in mid-dispense must stop the motor at once
    jam = 1'b0;
    award = 1'b1;
    repeat (10) step;
    nrst = 1'b0;
    award = 1'b0;
    step;
    `CHK(motor_drive, 1'b0)
    `CHK(busy, 1'b0)
    nrst = 1'b1;
    run(8'h02, 1'b1, 1'b1, 1'b0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
